// File: core/lfs_pkg.sv
// Package for the laser fault supervisor: register map, field layout, timing.
// Assumes a 50 MHz clock and a single synchronous active-high reset.
package lfs_pkg;

    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int CLK_HZ          = 50_000_000;
    localparam int BLANK_STEP_NS   = 500_000;
    localparam int BLANK_STEP_CYC  = (BLANK_STEP_NS / 1000) * (CLK_HZ / 1_000_000);

    // ********************************************************************
    // Register offsets
    // ********************************************************************
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_MASK     = 8'h01;
    localparam logic [7:0] ADDR_BLANK    = 8'h02;
    localparam logic [7:0] ADDR_CFG0     = 8'h03;
    localparam logic [7:0] ADDR_CFG1     = 8'h04;
    localparam logic [7:0] ADDR_CFG3     = 8'h05;
    localparam logic [7:0] ADDR_CFG5     = 8'h06;
    localparam logic [7:0] ADDR_LOS_ON   = 8'h07;
    localparam logic [7:0] ADDR_LOS_OFF  = 8'h08;
    localparam logic [7:0] ADDR_BIAS_SET = 8'h09;
    localparam logic [7:0] ADDR_MOD_SET  = 8'h0A;
    localparam logic [7:0] ADDR_APC_SET  = 8'h0B;
    localparam logic [7:0] ADDR_TEMP     = 8'h0C;
    localparam logic [7:0] ADDR_LUT_BASE = 8'h40;

    // ********************************************************************
    // Field positions
    // ********************************************************************
    localparam int CTRL_SOFT_DIS   = 0;
    localparam int CTRL_FAULT      = 1;
    localparam int CTRL_LOS        = 2;
    localparam int CFG0_MOD_REF    = 0;
    localparam int CFG0_DIODE_FLT  = 1;
    localparam int CFG0_OUT_EN     = 2;
    localparam int CFG0_HT_ALARM   = 3;
    localparam int CFG0_HT_WARN    = 4;
    localparam int CFG1_SW_POL     = 0;
    localparam int CFG1_BIAS_REF   = 5;
    localparam int CFG3_LOS_DIS    = 0;
    localparam int CFG3_EXT_FN     = 1;
    localparam int CFG3_EXT_POL    = 2;
    localparam int CFG5_SW_EN      = 7;
    localparam int NUM_SRC         = 5;
    localparam int SRC_SUPPLY      = 0;
    localparam int SRC_DIODE       = 1;
    localparam int SRC_BIAS        = 2;
    localparam int SRC_POWER       = 3;
    localparam int SRC_SAT         = 4;

    // ********************************************************************
    // Reset values and constants
    // ********************************************************************
    localparam logic [7:0] RST_ZERO     = 8'h00;
    localparam logic [7:0] BLANK_DEF    = 8'h01;
    localparam logic [7:0] TEMP_FULL    = 8'h7F;
    localparam int         LUT_DEPTH    = 64;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } lfs_bus_s;

    typedef struct packed {
        logic       out;
        logic       oe;
    } lfs_pin_s;

endpackage

// File: core/lfs_top.sv
// Laser fault supervisor: fault combining, latching, shutdown, LOS hysteresis.
// Assumes comparator results, temperature samples and pins arrive synchronous.
// Function
// - Watch five internal fault sources.
// - Unmasked fault shuts laser, asserts transmit fault.
// - Each source masked by its own bit.
// - Blank saturation 0.5ms steps after turn-on.
// - Non-saturation faults respond well under 100ms.
// - Out-of-range temperature flags diode fault.
// - LOS asserts below, releases above separate levels.
// - LOS disable frees line for external driver.
// - Control register reports actual LOS pin.
// - Bias fault threshold uses own table.
// - Bias/mod levels from config bits, fault or not; switch in fault if config bit7.
// - Switch active when laser is off; during a fault only if config bit7.
// - Switch polarity set by configuration bit.
// - Pin-function bit makes shared pin input.
// - External fault polarity selectable.
// - External fault ORed into transmit fault.
// - New temperature loads table-corrected converter values.
// - Diode fault forces temperature to 127.
// - Diode fault sets flag, fault, alarms.
// - No diode fault before first conversion.
// - Switch floats unless enabled; level by polarity.
// - Bias and modulation float unless enabled.
`timescale 1ns/10ps
`default_nettype none

module lfs_top (
    // Clock and reset
    input  wire  logic                 ref_clk,
    input  wire  logic                 rst,
    // Register port
    input  wire  lfs_pkg::lfs_bus_s    bus,
    output logic [7:0]                 rdata,
    // Fault comparators and temperature converter
    input  wire  logic                 supply_low,
    input  wire  logic                 bias_high,
    input  wire  logic                 power_high,
    input  wire  logic                 loop_saturated,
    input  wire  logic                 temp_valid,
    input  wire  logic [7:0]           temp_sample,
    input  wire  logic                 temp_out_of_range,
    input  wire  logic [7:0]           rx_power_input,
    // Host pins
    input  wire  logic                 transmit_disable_in,
    output logic                       transmit_fault_out,
    input  wire  logic                 rx_signal_loss_in,
    output lfs_pkg::lfs_pin_s          rx_signal_loss_out,
    // Shared switch / external fault pin
    input  wire  logic                 shared_pin_in,
    output lfs_pkg::lfs_pin_s          safety_switch_out,
    // Laser control converters
    output lfs_pkg::lfs_pin_s          bias_output,
    output lfs_pkg::lfs_pin_s          modulation_output,
    output logic [7:0]                 bias_dac,
    output logic [7:0]                 mod_dac,
    output logic [7:0]                 bias_fault_dac,
    output logic [7:0]                 temp_report,
    output logic                       laser_on
);

    // ********************************************************************
    // Registers
    // ********************************************************************
    logic [7:0]  ctrl_reg, fault_mask, saturation_blank_interval;
    logic [7:0]  cfg0_reg, option_config_one, option_config_three, option_config_five;
    logic [7:0]  los_assert_level, los_deassert_level;
    logic [7:0]  bias_set_reg, mod_set_reg, apc_set_reg;
    logic [7:0]  lut_mod [lfs_pkg::LUT_DEPTH];
    logic [7:0]  lut_apc [lfs_pkg::LUT_DEPTH];
    logic [7:0]  lut_flt [lfs_pkg::LUT_DEPTH];
    logic [4:0]  latch_reg;
    logic        ext_latch_reg;
    logic        diode_fault_flag_reg;
    logic        conv_done_reg;
    logic        txdis_seen_reg;
    logic        los_state_reg;
    logic        laser_on_reg;
    logic [15:0] step_cnt_reg;
    logic [7:0]  blank_cnt_reg;
    logic [7:0]  temp_reg;

    wire logic soft_transmit_disable = ctrl_reg[lfs_pkg::CTRL_SOFT_DIS];
    wire logic out_en     = cfg0_reg[lfs_pkg::CFG0_OUT_EN];
    wire logic ext_mode   = option_config_three[lfs_pkg::CFG3_EXT_FN];
    wire logic los_off    = option_config_three[lfs_pkg::CFG3_LOS_DIS];
    wire logic [1:0] lut_sel = bus.addr[7:6] - 2'd1;
    wire logic [5:0] lut_idx = bus.addr[5:0];

    // ********************************************************************
    // Fault detection
    // ********************************************************************
    wire logic blanking = (blank_cnt_reg != 8'h00);
    wire logic diode_now = temp_out_of_range & conv_done_reg;
    wire logic [4:0] raw_src = {loop_saturated & ~blanking & laser_on_reg,
                                power_high, bias_high, diode_now, supply_low};
    wire logic [4:0] live_src = raw_src & ~fault_mask[4:0];
    // While the switch driver still holds the pin, it only echoes our own level.
    wire logic ext_fault = ext_mode & ~safety_switch_out.oe &
                           (shared_pin_in ~^ option_config_three[lfs_pkg::CFG3_EXT_POL]);
    wire logic any_fault = (|live_src) | (|latch_reg) | ext_fault | ext_latch_reg;
    wire logic clear_ok = txdis_seen_reg & ~(|live_src) & ~ext_fault;
    wire logic laser_off = transmit_disable_in | soft_transmit_disable | any_fault;
    wire logic switch_active = laser_off & (~any_fault | option_config_five[lfs_pkg::CFG5_SW_EN]);
    wire logic los_next = los_off ? 1'b0 :
                          (rx_power_input < los_assert_level) ? 1'b1 :
                          (rx_power_input > los_deassert_level) ? 1'b0 : los_state_reg;
    wire logic [7:0] temp_idx = (temp_sample[7] ? 8'h00 : temp_sample) >> 1;
    wire logic [5:0] tidx = (temp_idx > 8'd63) ? 6'd63 : temp_idx[5:0];
    wire logic [7:0] ctrl_rd = {5'b0, rx_signal_loss_in, any_fault, soft_transmit_disable};
    // Status flags are read from the latched diode fault flag, which holds until the fault is cleared.
    wire logic alarms = diode_fault_flag_reg;
    wire logic [7:0] cfg0_rd = cfg0_reg | {3'b000, alarms, alarms, 1'b0, alarms, 1'b0};
    wire logic [7:0] rd_mux =
        (bus.addr == lfs_pkg::ADDR_CTRL)    ? ctrl_rd :
        (bus.addr == lfs_pkg::ADDR_MASK)    ? fault_mask :
        (bus.addr == lfs_pkg::ADDR_BLANK)   ? saturation_blank_interval :
        (bus.addr == lfs_pkg::ADDR_CFG0)    ? cfg0_rd :
        (bus.addr == lfs_pkg::ADDR_CFG1)    ? option_config_one :
        (bus.addr == lfs_pkg::ADDR_CFG3)    ? option_config_three :
        (bus.addr == lfs_pkg::ADDR_CFG5)    ? option_config_five :
        (bus.addr == lfs_pkg::ADDR_LOS_ON)  ? los_assert_level :
        (bus.addr == lfs_pkg::ADDR_LOS_OFF) ? los_deassert_level :
        (bus.addr == lfs_pkg::ADDR_TEMP)    ? temp_reg : 8'h00;

    // ********************************************************************
    // Register write port and table storage
    // ********************************************************************
    always_ff @(posedge ref_clk) begin
        if (bus.wr && bus.addr >= lfs_pkg::ADDR_LUT_BASE) begin
            case (lut_sel)
                2'd0: lut_apc[lut_idx] <= bus.wdata;
                2'd1: lut_mod[lut_idx] <= bus.wdata;
                2'd2: lut_flt[lut_idx] <= bus.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_reg <= lfs_pkg::RST_ZERO;
            fault_mask <= lfs_pkg::RST_ZERO;
            saturation_blank_interval <= lfs_pkg::BLANK_DEF;
            cfg0_reg <= lfs_pkg::RST_ZERO;
            option_config_one <= lfs_pkg::RST_ZERO;
            option_config_three <= lfs_pkg::RST_ZERO;
            option_config_five <= lfs_pkg::RST_ZERO;
            los_assert_level <= lfs_pkg::RST_ZERO;
            los_deassert_level <= lfs_pkg::RST_ZERO;
            bias_set_reg <= lfs_pkg::RST_ZERO;
            mod_set_reg <= lfs_pkg::RST_ZERO;
            apc_set_reg <= lfs_pkg::RST_ZERO;
            rdata <= 8'h00;
        end else begin
            rdata <= bus.rd ? rd_mux : 8'h00;
            if (bus.wr) begin
                case (bus.addr)
                    lfs_pkg::ADDR_CTRL:     ctrl_reg <= {7'b0, bus.wdata[lfs_pkg::CTRL_SOFT_DIS]};
                    lfs_pkg::ADDR_MASK:     fault_mask <= {3'b0, bus.wdata[4:0]};
                    lfs_pkg::ADDR_BLANK:    saturation_blank_interval <= bus.wdata;
                    lfs_pkg::ADDR_CFG0:     cfg0_reg <= bus.wdata & 8'h05;
                    lfs_pkg::ADDR_CFG1:     option_config_one <= bus.wdata;
                    lfs_pkg::ADDR_CFG3:     option_config_three <= bus.wdata;
                    lfs_pkg::ADDR_CFG5:     option_config_five <= bus.wdata;
                    lfs_pkg::ADDR_LOS_ON:   los_assert_level <= bus.wdata;
                    lfs_pkg::ADDR_LOS_OFF:  los_deassert_level <= bus.wdata;
                    lfs_pkg::ADDR_BIAS_SET: bias_set_reg <= bus.wdata;
                    lfs_pkg::ADDR_MOD_SET:  mod_set_reg <= bus.wdata;
                    lfs_pkg::ADDR_APC_SET:  apc_set_reg <= bus.wdata;
                    default: ;
                endcase
            end
        end
    end

    // ********************************************************************
    // Fault latches and laser state
    // ********************************************************************
    genvar g;
    generate
        for (g = 0; g < lfs_pkg::NUM_SRC; g++) begin : g_latch
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    latch_reg[g] <= 1'b0;
                end else if (live_src[g]) begin
                    latch_reg[g] <= 1'b1;
                end else if (clear_ok) begin
                    latch_reg[g] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ext_latch_reg <= 1'b0;
            txdis_seen_reg <= 1'b0;
            diode_fault_flag_reg <= 1'b0;
            conv_done_reg <= 1'b0;
            laser_on_reg <= 1'b0;
            los_state_reg <= 1'b0;
        end else begin
            ext_latch_reg <= ext_fault | (ext_latch_reg & ~clear_ok);
            if (transmit_disable_in && any_fault) begin
                txdis_seen_reg <= 1'b1;
            end else if (!any_fault) begin
                txdis_seen_reg <= 1'b0;
            end
            diode_fault_flag_reg <= diode_now | (diode_fault_flag_reg & ~clear_ok);
            if (temp_valid) begin
                conv_done_reg <= 1'b1;
            end
            laser_on_reg <= ~laser_off;
            los_state_reg <= los_next;
        end
    end

    // ********************************************************************
    // Saturation blanking timer
    // ********************************************************************
    // The timer restarts on each off-to-on transition; a fault cannot slip past.
    wire logic turn_on = ~laser_off & ~laser_on_reg;
    wire logic step_end = (step_cnt_reg == 16'(lfs_pkg::BLANK_STEP_CYC - 1));

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            step_cnt_reg <= 16'h0000;
            blank_cnt_reg <= 8'h00;
        end else if (turn_on) begin
            step_cnt_reg <= 16'h0000;
            blank_cnt_reg <= saturation_blank_interval;
        end else begin
            step_cnt_reg <= step_end ? 16'h0000 : step_cnt_reg + 16'h0001;
            if (step_end && blanking) begin
                blank_cnt_reg <= blank_cnt_reg - 8'h01;
            end
        end
    end

    // ********************************************************************
    // Temperature compensation and outputs
    // ********************************************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            temp_reg <= 8'h00;
            bias_dac <= 8'h00;
            mod_dac <= 8'h00;
            bias_fault_dac <= 8'h00;
        end else if (diode_fault_flag_reg || diode_now) begin
            temp_reg <= lfs_pkg::TEMP_FULL;
        end else if (temp_valid) begin
            temp_reg <= temp_sample;
            mod_dac <= mod_set_reg + lut_mod[tidx];
            bias_dac <= apc_set_reg + lut_apc[tidx];
            bias_fault_dac <= bias_set_reg + lut_flt[tidx];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            transmit_fault_out <= 1'b0;
            rx_signal_loss_out <= '0;
            safety_switch_out <= '0;
            bias_output <= '0;
            modulation_output <= '0;
            temp_report <= 8'h00;
            laser_on <= 1'b0;
        end else begin
            transmit_fault_out <= any_fault;
            rx_signal_loss_out <= '{out: los_next, oe: ~los_off};
            safety_switch_out.oe <= out_en & ~ext_mode;
            safety_switch_out.out <= switch_active ~^
                                     option_config_one[lfs_pkg::CFG1_SW_POL];
            bias_output <= '{out: option_config_one[lfs_pkg::CFG1_BIAS_REF], oe: out_en};
            modulation_output <= '{out: cfg0_reg[lfs_pkg::CFG0_MOD_REF], oe: out_en};
            temp_report <= (diode_fault_flag_reg | diode_now) ? lfs_pkg::TEMP_FULL : temp_reg;
            laser_on <= ~laser_off;
        end
    end

    // ********************************************************************
    // Checks
    // ********************************************************************
    a_fault_shuts: assert property (@(posedge ref_clk) disable iff (rst)
        (|live_src) |=> transmit_fault_out && !laser_on) else $error("fault not shut");
    a_mask_blocks: assert property (@(posedge ref_clk) disable iff (rst)
        (fault_mask[0] && supply_low && !any_fault) |=> !latch_reg[0])
        else $error("mask ignored");
    a_blank_holds: assert property (@(posedge ref_clk) disable iff (rst)
        turn_on && saturation_blank_interval != 0 |=> blanking) else $error("no blank");
    a_los_hyst: assert property (@(posedge ref_clk) disable iff (rst)
        !los_off && rx_power_input < los_assert_level |=> rx_signal_loss_out.out)
        else $error("los late");
    a_los_free: assert property (@(posedge ref_clk) disable iff (rst)
        los_off |=> !rx_signal_loss_out.oe) else $error("los driven");
    a_temp_full: assert property (@(posedge ref_clk) disable iff (rst)
        diode_now |=> temp_report == lfs_pkg::TEMP_FULL) else $error("temp not full");
    a_ext_or: assert property (@(posedge ref_clk) disable iff (rst)
        ext_fault |=> transmit_fault_out) else $error("ext fault lost");
    a_latch_hold: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(latch_reg[1]) && !clear_ok |=> latch_reg[1]) else $error("latch dropped");
    a_switch_oe: assert property (@(posedge ref_clk) disable iff (rst)
        !out_en |=> !safety_switch_out.oe && !bias_output.oe) else $error("oe leak");

endmodule

`default_nettype wire

// File: dv/lfs_host_model.sv
// Host side model: external fault driver on the shared pin and LOS line.
// Assumes the supervisor drives both pins as {out,oe} pairs.
`timescale 1ns/10ps
`default_nettype none

module lfs_host_model (
    // Supervisor pin drives
    input  wire lfs_pkg::lfs_pin_s safety_switch_out,
    input  wire lfs_pkg::lfs_pin_s rx_signal_loss_out,
    // External driver levels
    input  wire logic              ext_fault_level,
    input  wire logic              ext_los_level,
    // Resolved pin levels
    output logic                   shared_pin_in,
    output logic                   rx_signal_loss_in
);
    // A released pin is taken over by the external driver, so no stale level lingers.
    assign shared_pin_in     = safety_switch_out.oe ? safety_switch_out.out : ext_fault_level;
    assign rx_signal_loss_in = rx_signal_loss_out.oe ? rx_signal_loss_out.out : ext_los_level;
endmodule

`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the laser fault supervisor.
// Assumes the host model resolves the shared pin and the LOS line.
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic              ref_clk, rst, loop_saturated, temp_valid, transmit_disable_in;
    logic              transmit_fault_out, laser_on, rx_signal_loss_in, shared_pin_in;
    logic              ext_fault_level, ext_los_level, los_e;
    logic [7:0]        rdata, rx_power_input, temp_sample, temp_report, d, v;
    logic [7:0]        bias_dac, mod_dac, bias_fault_dac;
    logic [3:0]        src_v;
    logic [31:0]       rnd;
    lfs_pkg::lfs_bus_s bus;
    lfs_pkg::lfs_pin_s rx_signal_loss_out, safety_switch_out, bias_output, modulation_output;
    int                n_errors, samples_checked, cycles;
    logic [7:0]        corner [4] = '{8'h0040, 8'h003F, 8'h0080, 8'h0081};
    wire logic         supply_low        = src_v[0];
    wire logic         temp_out_of_range = src_v[1];
    wire logic         bias_high         = src_v[2];
    wire logic         power_high        = src_v[3];

    lfs_top uut (
        .ref_clk(ref_clk), .rst(rst), .bus(bus), .rdata(rdata),
        .supply_low(supply_low), .bias_high(bias_high), .power_high(power_high),
        .loop_saturated(loop_saturated), .temp_valid(temp_valid), .temp_sample(temp_sample),
        .temp_out_of_range(temp_out_of_range), .rx_power_input(rx_power_input),
        .transmit_disable_in(transmit_disable_in), .transmit_fault_out(transmit_fault_out),
        .rx_signal_loss_in(rx_signal_loss_in), .rx_signal_loss_out(rx_signal_loss_out),
        .shared_pin_in(shared_pin_in), .safety_switch_out(safety_switch_out),
        .bias_output(bias_output), .modulation_output(modulation_output),
        .bias_dac(bias_dac), .mod_dac(mod_dac), .bias_fault_dac(bias_fault_dac),
        .temp_report(temp_report), .laser_on(laser_on)
    );
    lfs_host_model host (
        .safety_switch_out(safety_switch_out), .rx_signal_loss_out(rx_signal_loss_out),
        .ext_fault_level(ext_fault_level), .ext_los_level(ext_los_level),
        .shared_pin_in(shared_pin_in), .rx_signal_loss_in(rx_signal_loss_in)
    );

    // ********************************************************************
    // Bench tasks
    // ********************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Hysteresis: assert strictly below one level, release strictly above the other.
    function automatic logic los_next(input logic p, input logic [7:0] x);
        return (x < 8'h0040) ? 1'b1 : ((x > 8'h0080) ? 1'b0 : p);
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        @(posedge ref_clk) bus <= '{a, x, 1'b1, 1'b0};
        @(posedge ref_clk) bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk) bus <= '{a, 8'h0000, 1'b0, 1'b1};
        @(posedge ref_clk) bus.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic chk(input bit ok, input string m);
        samples_checked++;
        if (!ok) begin
            n_errors++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic conv;
        rnd = lfsr(rnd);
        @(posedge ref_clk) temp_valid <= 1'b1;
        temp_sample <= rnd[7:0];
        @(posedge ref_clk) temp_valid <= 1'b0;
    endtask
    // Faults only clear on a disable toggle once every cause is gone.
    task automatic clr;
        @(posedge ref_clk) src_v <= 4'h0;
        loop_saturated <= 1'b0;
        transmit_disable_in <= 1'b1;
        tick(4);
        @(posedge ref_clk) transmit_disable_in <= 1'b0;
        tick(4);
    endtask
    task automatic conclude;
        $display("errors %0d, checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 40000) begin
            n_errors++;
            conclude();
        end
    end

    // ********************************************************************
    // Main sequence
    // ********************************************************************
    initial begin
        {rst, ext_fault_level, rx_power_input} = {1'b1, 1'b1, 8'h00FF};
        {loop_saturated, temp_valid, transmit_disable_in, ext_los_level, los_e} = '0;
        {bus, src_v, temp_sample, rnd} = {18'h0_0000, 4'h0, 8'h0000, 32'h287f};
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        tick(1);
        chk(bias_output.oe === 1'b0 && modulation_output.oe === 1'b0, "bias/mod float");
        chk(safety_switch_out.oe === 1'b0, "switch float");
        rd(lfs_pkg::ADDR_BLANK);
        chk(d === lfs_pkg::BLANK_DEF, "blank reset value");
        rd(8'h0020);
        chk(d === 8'h0000, "unmapped read");
        @(posedge ref_clk) src_v <= 4'h2;
        tick(5);
        chk(transmit_fault_out === 1'b0, "early diode fault");
        clr();
        wr(lfs_pkg::ADDR_CFG0, 8'h0005);
        wr(lfs_pkg::ADDR_CFG1, 8'h0020);
        wr(lfs_pkg::ADDR_CFG5, 8'h0080);
        for (int i = 0; i < 4; i++) begin
            wr(lfs_pkg::ADDR_MASK, 8'(1 << i));
            @(posedge ref_clk) src_v[i] <= 1'b1;
            conv();
            tick(5);
            chk(transmit_fault_out === 1'b0, "masked source");
            wr(lfs_pkg::ADDR_MASK, 8'h0000);
            tick(2);
            chk(transmit_fault_out === 1'b1 && laser_on === 1'b0, "fault shutdown");
            chk(bias_output === 2'b11 && modulation_output === 2'b11, "shutdown levels");
            chk(safety_switch_out === 2'b01, "switch level");
            if (i == 1) begin
                chk(temp_report === lfs_pkg::TEMP_FULL, "diode temperature");
                rd(lfs_pkg::ADDR_CFG0);
                chk(d[1] === 1'b1 && d[3] === 1'b1 && d[4] === 1'b1, "diode flags");
            end
            @(posedge ref_clk) src_v <= 4'h0;
            tick(5);
            chk(transmit_fault_out === 1'b1, "fault latch");
            clr();
            chk(transmit_fault_out === 1'b0, "fault clear");
        end
        for (int p = 0; p < 2; p++) begin
            wr(lfs_pkg::ADDR_CFG1, 8'h0020 | 8'(p));
            @(posedge ref_clk) transmit_disable_in <= 1'b1;
            tick(3);
            chk(safety_switch_out === {p[0], 1'b1}, "switch on disable");
            @(posedge ref_clk) transmit_disable_in <= 1'b0;
            tick(3);
            chk(safety_switch_out === {~p[0], 1'b1}, "switch idle");
            wr(lfs_pkg::ADDR_CTRL, 8'h0001);
            tick(2);
            chk(safety_switch_out.out === p[0], "soft disable");
            wr(lfs_pkg::ADDR_CTRL, 8'h0000);
        end
        clr();
        @(posedge ref_clk) loop_saturated <= 1'b1;
        tick(24000);
        chk(transmit_fault_out === 1'b0, "blank window");
        tick(1100);
        chk(transmit_fault_out === 1'b1, "saturation fault");
        clr();
        for (int p = 0; p < 2; p++) begin
            @(posedge ref_clk) ext_fault_level <= ~p[0];
            wr(lfs_pkg::ADDR_CFG3, 8'h0002 | 8'(p << 2));
            tick(3);
            chk(transmit_fault_out === 1'b0 && safety_switch_out.oe === 1'b0, "ext idle");
            @(posedge ref_clk) ext_fault_level <= p[0];
            tick(3);
            rd(lfs_pkg::ADDR_CTRL);
            chk(transmit_fault_out === 1'b1 && d[1] === 1'b1, "ext fault");
            wr(lfs_pkg::ADDR_CFG3, 8'h0000);
            clr();
        end
        wr(lfs_pkg::ADDR_LOS_ON, 8'h0040);
        wr(lfs_pkg::ADDR_LOS_OFF, 8'h0080);
        for (int k = 0; k < 48; k++) begin
            rnd = lfsr(rnd);
            v = (k < 4) ? corner[k] : rnd[7:0];
            @(posedge ref_clk) rx_power_input <= v;
            los_e = los_next(los_e, v);
            tick(3);
            chk(rx_signal_loss_out === {los_e, 1'b1}, "los level");
        end
        wr(lfs_pkg::ADDR_CFG3, 8'h0001);
        for (int k = 0; k < 2; k++) begin
            @(posedge ref_clk) ext_los_level <= k[0];
            tick(2);
            rd(lfs_pkg::ADDR_CTRL);
            chk(rx_signal_loss_out.oe === 1'b0 && d[2] === k[0], "los pin report");
        end
        wr(lfs_pkg::ADDR_APC_SET, 8'h20);
        wr(lfs_pkg::ADDR_MOD_SET, 8'h10);
        wr(lfs_pkg::ADDR_BIAS_SET, 8'h30);
        for (int j = 0; j < 2; j++) begin
            v = (j == 0) ? 8'h0A : 8'hF0;
            d = v[7] ? 8'h00 : {2'b00, v[6:1]};
            wr(8'h40 | d, 8'h03);
            wr(8'h80 | d, 8'h04);
            wr(8'hC0 | d, 8'h05);
            @(posedge ref_clk) temp_valid <= 1'b1;
            temp_sample <= v;
            @(posedge ref_clk) temp_valid <= 1'b0;
            tick(2);
            chk(bias_dac === 8'h23 && mod_dac === 8'h14 && temp_report === v, "table load");
            chk(bias_fault_dac === 8'h35, "bias fault table");
        end
        conclude();
    end
endmodule

`default_nettype wire
